// [hw/tmcc_pkg.sv]
// constants shared by the timer module common core
package tmcc_pkg;
   // counter variants
   localparam logic [1:0] TMCC_VAR_COMPACT = 2'h0;
   localparam logic [1:0] TMCC_VAR_STANDARD = 2'h1;
   localparam logic [1:0] TMCC_VAR_ENHANCED = 2'h2;
   localparam logic [15:0] TMCC_MAX_10BIT = 16'h03FF;
   localparam logic [15:0] TMCC_MAX_16BIT = 16'hFFFF;
   // clock_source_select codes
   localparam logic [2:0] TMCC_CK_SYS_DIV4 = 3'h0;
   localparam logic [2:0] TMCC_CK_SYS = 3'h1;
   localparam logic [2:0] TMCC_CK_HIGH_DIV16 = 3'h2;
   localparam logic [2:0] TMCC_CK_HIGH_DIV64 = 3'h3;
   localparam logic [2:0] TMCC_CK_TIMEBASE = 3'h4;
   localparam logic [2:0] TMCC_CK_RESERVED = 3'h5;
   localparam logic [2:0] TMCC_CK_EXT_RISE = 3'h6;
   localparam logic [2:0] TMCC_CK_EXT_FALL = 3'h7;
   // divider terminal counts
   localparam logic [1:0] TMCC_SYS_DIV4_LAST = 2'h3;
   localparam logic [5:0] TMCC_HIGH_DIV16_LAST = 6'h0F;
   localparam logic [5:0] TMCC_HIGH_DIV64_LAST = 6'h3F;
   // operating modes
   localparam logic [1:0] TMCC_MODE_COMPARE = 2'h0;
   localparam logic [1:0] TMCC_MODE_PWM = 2'h2;
   localparam logic [1:0] TMCC_MODE_TIMER = 2'h3;
   // output function codes
   localparam logic [1:0] TMCC_OUT_NONE = 2'h0;
   localparam logic [1:0] TMCC_OUT_LOW = 2'h1;
   localparam logic [1:0] TMCC_OUT_HIGH = 2'h2;
   localparam logic [1:0] TMCC_OUT_TOGGLE = 2'h3;
   localparam logic [1:0] TMCC_PWM_INACTIVE = 2'h0;
   localparam logic [1:0] TMCC_PWM_ACTIVE = 2'h1;
   localparam logic [1:0] TMCC_PWM_WAVE = 2'h2;
   // byte register select
   localparam logic [2:0] TMCC_SEL_COUNT_LO = 3'h0;
   localparam logic [2:0] TMCC_SEL_COUNT_HI = 3'h1;
   localparam logic [2:0] TMCC_SEL_CMPA_LO = 3'h2;
   localparam logic [2:0] TMCC_SEL_CMPA_HI = 3'h3;
   localparam logic [2:0] TMCC_SEL_CMPB_LO = 3'h4;
   localparam logic [2:0] TMCC_SEL_CMPB_HI = 3'h5;
   // reset values
   localparam logic [15:0] TMCC_COUNT_RST = 16'h0000;
   localparam logic [15:0] TMCC_CMP_RST = 16'h0000;
   localparam logic [7:0] TMCC_BYTE_RST = 8'h00;
   // period compare width and position below the counter top
   localparam int TMCC_PERIOD_SHIFT_10 = 7;
   localparam int TMCC_PERIOD_SHIFT_16 = 13;
endpackage

// [hw/tmcc_clk_sel.sv]
// counter tick generation from the selected clock source
`timescale 1ns/1ps
module tmcc_clk_sel
   import tmcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] clock_source_select,
   input wire logic high_clk_tick,
   input wire logic timebase_tick,
   input wire logic external_timer_input,
   output logic count_tick_r
);
   logic [1:0] sys_div_r;
   logic [5:0] high_div_r;
   logic ext_meta_r;
   logic ext_sync_r;
   logic ext_prev_r;
   logic ext_sel;
   logic tick_nxt;

   // pin only reaches the counter when an external code is chosen
   assign ext_sel = (clock_source_select == TMCC_CK_EXT_RISE) ||
                    (clock_source_select == TMCC_CK_EXT_FALL);

   always_ff @(posedge clk)
   begin
      if (rst)
         sys_div_r <= 2'h0;
      else
         sys_div_r <= sys_div_r + 2'h1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         high_div_r <= 6'h00;
      else if (high_clk_tick)
         high_div_r <= high_div_r + 6'h01;
   end

   // two flops then an edge detector keep all counting on clk
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= external_timer_input & ext_sel;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   always_comb
   begin
      tick_nxt = 1'b0;
      unique case (clock_source_select)
         TMCC_CK_SYS_DIV4: tick_nxt = (sys_div_r == TMCC_SYS_DIV4_LAST);
         TMCC_CK_SYS: tick_nxt = 1'b1;
         TMCC_CK_HIGH_DIV16:
            tick_nxt = high_clk_tick && (high_div_r[3:0] == TMCC_HIGH_DIV16_LAST[3:0]);
         TMCC_CK_HIGH_DIV64:
            tick_nxt = high_clk_tick && (high_div_r == TMCC_HIGH_DIV64_LAST);
         TMCC_CK_TIMEBASE: tick_nxt = timebase_tick;
         TMCC_CK_RESERVED: tick_nxt = 1'b0;
         TMCC_CK_EXT_RISE: tick_nxt = ext_sync_r & ~ext_prev_r;
         TMCC_CK_EXT_FALL: tick_nxt = ~ext_sync_r & ext_prev_r;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         count_tick_r <= 1'b0;
      else
         count_tick_r <= tick_nxt;
   end
endmodule

// [hw/tmcc_core.sv]
// timer module common core: counter, comparators, outputs, byte access
//
// Notes on behaviour
// - counter clock picked by three-bit select among internal ratios and pin.
// - reserved select code 101 gives no counter clock.
// - external input counts on a selectable rising or falling edge.
// - pin feeds counter only while an external select code is set.
// - counter equal to a comparator value raises that comparator's interrupt.
// - a match may clear the counter and change the output pin.
// - compact and standard variants have comparator A and P interrupts.
// - enhanced variant adds comparator B, three interrupts in all.
// - compare output mode drives pin high, low or toggles on match.
// - PWM waveform appears on the timer output pin.
// - two output pins form a complementary pair with per-pin polarity.
// - high bytes accessed directly, low bytes through an eight-bit buffer.
// - low byte compare write only loads the buffer.
// - high byte compare write stores high and moves buffer to low.
// - high byte read returns high and captures live low into buffer.
// - low byte read returns the buffer contents.
// - four timers; compact and enhanced ten-bit, standard sixteen-bit.
// - code 000 is system clock over four, 110 rising, 111 falling pin.
// - run switch off-to-on zeroes counter; on-to-off keeps its value.
`timescale 1ns/1ps
module tmcc_core
   import tmcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] timer_variant,
   input wire logic [2:0] clock_source_select,
   input wire logic counter_run_switch,
   input wire logic counter_pause,
   input wire logic [2:0] period_compare_value,
   input wire logic [1:0] operating_mode,
   input wire logic [1:0] output_function,
   input wire logic output_initial_level,
   input wire logic [1:0] output_polarity,
   input wire logic clear_on_compare_a,
   input wire logic high_clk_tick,
   input wire logic timebase_tick,
   input wire logic external_timer_input,
   input wire logic [2:0] byte_sel,
   input wire logic byte_rd,
   input wire logic byte_wr,
   input wire logic [7:0] byte_wr_data,
   output logic [7:0] byte_rd_data_r,
   output logic byte_rd_valid_r,
   output logic irq_compare_a_r,
   output logic irq_compare_b_r,
   output logic irq_period_r,
   output logic [1:0] timer_output_pin_r,
   output logic timer_output_enable_r
);
   logic count_tick_r;
   logic [15:0] count_r;
   logic [15:0] cmp_a_r;
   logic [15:0] cmp_b_r;
   logic [7:0] low_buf_r;
   logic run_prev_r;
   logic fresh_r;
   logic out_level_r;
   logic run_rise;
   logic [15:0] max_val;
   logic [15:0] period_val;
   logic match_a;
   logic match_b;
   logic match_p;
   logic eq_a;
   logic eq_p;
   logic do_clear;
   logic pwm_level;

   // width of the counter for this variant
   function automatic logic [15:0] tmcc_max(input logic [1:0] variant);
      tmcc_max = (variant == TMCC_VAR_STANDARD) ? TMCC_MAX_16BIT : TMCC_MAX_10BIT;
   endfunction

   // high byte of a register, with bits above the variant's counter width cleared
   function automatic logic [7:0] tmcc_hi(input logic [15:0] value, input logic [15:0] mask);
      logic [15:0] masked;
      masked = value & mask;
      tmcc_hi = masked[15:8];
   endfunction

   tmcc_clk_sel u_clk_sel
   (
      .clk(clk),
      .rst(rst),
      .clock_source_select(clock_source_select),
      .high_clk_tick(high_clk_tick),
      .timebase_tick(timebase_tick),
      .external_timer_input(external_timer_input),
      .count_tick_r(count_tick_r)
   );

   assign max_val = tmcc_max(timer_variant);
   assign run_rise = counter_run_switch & ~run_prev_r;

   // period value sets the top three counter bits with the lower bits zero, compared against the whole counter; zero means full range
   always_comb
   begin
      if (period_compare_value == 3'h0)
         period_val = max_val;
      else if (timer_variant == TMCC_VAR_STANDARD)
         period_val = {period_compare_value, 13'h0000};
      else
         period_val = {6'h00, period_compare_value, 7'h00};
   end

   // equality stands until the next tick, which is when the clear lands
   assign eq_a = (count_r == (cmp_a_r & max_val));
   assign eq_p = (count_r == period_val);
   // fresh_r marks a newly reached value so a stalled counter fires once
   assign match_a = fresh_r && eq_a;
   assign match_b = fresh_r && (timer_variant == TMCC_VAR_ENHANCED) &&
                    (count_r == (cmp_b_r & max_val));
   assign match_p = fresh_r && eq_p;
   // slow clocks drop fresh_r before their tick, so clear on the held value
   assign do_clear = clear_on_compare_a ? eq_a : eq_p;

   always_ff @(posedge clk)
   begin
      if (rst)
         run_prev_r <= 1'b0;
      else
         run_prev_r <= counter_run_switch;
   end

   // counter: cleared on run rising edge, holds when off or paused
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_r <= TMCC_COUNT_RST;
         fresh_r <= 1'b0;
      end
      else if (run_rise)
      begin
         count_r <= TMCC_COUNT_RST;
         fresh_r <= 1'b1;
      end
      else if (counter_run_switch && !counter_pause && count_tick_r)
      begin
         if (do_clear || count_r == max_val)
            count_r <= TMCC_COUNT_RST;
         else
            count_r <= count_r + 16'h0001;
         fresh_r <= 1'b1;
      end
      else
         fresh_r <= 1'b0;
   end

   // interrupt requests are single-cycle pulses
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_compare_a_r <= 1'b0;
         irq_compare_b_r <= 1'b0;
         irq_period_r <= 1'b0;
      end
      else
      begin
         irq_compare_a_r <= match_a;
         irq_compare_b_r <= match_b;
         irq_period_r <= match_p;
      end
   end

   // pwm: active while counter is below comparator A within the period
   always_comb
   begin
      pwm_level = 1'b0;
      unique case (output_function)
         TMCC_PWM_INACTIVE: pwm_level = 1'b0;
         TMCC_PWM_ACTIVE: pwm_level = 1'b1;
         TMCC_PWM_WAVE: pwm_level = (count_r < (cmp_a_r & max_val));
         default: pwm_level = 1'b0;
      endcase
   end

   // output level before polarity
   always_ff @(posedge clk)
   begin
      if (rst)
         out_level_r <= 1'b0;
      else if (operating_mode == TMCC_MODE_PWM)
         out_level_r <= pwm_level;
      else if (operating_mode == TMCC_MODE_COMPARE)
      begin
         if (run_rise)
            out_level_r <= output_initial_level;
         else if (match_a)
         begin
            unique case (output_function)
               TMCC_OUT_NONE: out_level_r <= out_level_r;
               TMCC_OUT_LOW: out_level_r <= 1'b0;
               TMCC_OUT_HIGH: out_level_r <= 1'b1;
               TMCC_OUT_TOGGLE: out_level_r <= ~out_level_r;
            endcase
         end
      end
   end

   // complementary pair; one cycle behind the level, enable tracks mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timer_output_pin_r <= 2'h0;
         timer_output_enable_r <= 1'b0;
      end
      else
      begin
         timer_output_pin_r[0] <= out_level_r ^ output_polarity[0];
         timer_output_pin_r[1] <= ~out_level_r ^ output_polarity[1];
         timer_output_enable_r <= (operating_mode == TMCC_MODE_COMPARE) ||
                                  (operating_mode == TMCC_MODE_PWM);
      end
   end

   // compare registers; low byte only lands when the high byte is written
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmp_a_r <= TMCC_CMP_RST;
         cmp_b_r <= TMCC_CMP_RST;
      end
      else if (byte_wr)
      begin
         if (byte_sel == TMCC_SEL_CMPA_HI)
            cmp_a_r <= {byte_wr_data, low_buf_r} & max_val;
         else if (byte_sel == TMCC_SEL_CMPB_HI)
            cmp_b_r <= {byte_wr_data, low_buf_r} & max_val;
      end
   end

   // shared low-byte buffer
   always_ff @(posedge clk)
   begin
      if (rst)
         low_buf_r <= TMCC_BYTE_RST;
      else if (byte_wr && (byte_sel == TMCC_SEL_CMPA_LO || byte_sel == TMCC_SEL_CMPB_LO))
         low_buf_r <= byte_wr_data;
      else if (byte_rd)
      begin
         unique case (byte_sel)
            TMCC_SEL_COUNT_HI: low_buf_r <= count_r[7:0];
            TMCC_SEL_CMPA_HI: low_buf_r <= cmp_a_r[7:0];
            TMCC_SEL_CMPB_HI: low_buf_r <= cmp_b_r[7:0];
            default: low_buf_r <= low_buf_r;
         endcase
      end
   end

   // read data: high bytes live, low bytes from the buffer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         byte_rd_data_r <= TMCC_BYTE_RST;
         byte_rd_valid_r <= 1'b0;
      end
      else
      begin
         byte_rd_valid_r <= byte_rd;
         if (byte_rd)
         begin
            unique case (byte_sel)
               TMCC_SEL_COUNT_HI: byte_rd_data_r <= tmcc_hi(count_r, max_val);
               TMCC_SEL_CMPA_HI: byte_rd_data_r <= tmcc_hi(cmp_a_r, max_val);
               TMCC_SEL_CMPB_HI: byte_rd_data_r <= tmcc_hi(cmp_b_r, max_val);
               TMCC_SEL_COUNT_LO,
               TMCC_SEL_CMPA_LO,
               TMCC_SEL_CMPB_LO: byte_rd_data_r <= low_buf_r;
               default: byte_rd_data_r <= TMCC_BYTE_RST;
            endcase
         end
      end
   end
endmodule

// [verif/tmcc_ext_src.sv]
// external clock source model driving the timer input pin
`timescale 1ns/1ps
module tmcc_ext_src (
   input wire logic clk,
   output logic pin
);
   initial pin = 1'b0;
   // four cycles per level, above the three-cycle detection floor
   task automatic level(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (3) @(posedge clk);
   endtask
   // n rising edges; pin left high so only n-1 falling edges occur
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++)
      begin
         if (i > 0)
            level(1'b0);
         level(1'b1);
      end
   endtask
endmodule

// [verif/tmcc_core_assertions.sv]
// port-level assertions for the timer core
`timescale 1ns/1ps
module tmcc_core_assertions
   import tmcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] timer_variant,
   input wire logic [2:0] clock_source_select,
   input wire logic counter_run_switch,
   input wire logic [1:0] operating_mode,
   input wire logic [1:0] output_function,
   input wire logic [1:0] output_polarity,
   input wire logic [2:0] byte_sel,
   input wire logic byte_rd,
   input wire logic byte_wr,
   input wire logic [7:0] byte_wr_data,
   input wire logic [7:0] byte_rd_data_r,
   input wire logic byte_rd_valid_r,
   input wire logic irq_compare_a_r,
   input wire logic irq_compare_b_r,
   input wire logic irq_period_r,
   input wire logic [1:0] timer_output_pin_r,
   input wire logic timer_output_enable_r
);
   logic [7:0] hmask;
   assign hmask = (timer_variant == TMCC_VAR_STANDARD) ? 8'hFF : 8'h03;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_rd_valid_time: assert property (byte_rd_valid_r == $past(byte_rd))
      else $error("read valid timing wrong");
   a_unmapped_zero: assert property (byte_rd && byte_sel[2:1] == 2'h3
      |=> byte_rd_data_r == TMCC_BYTE_RST) else $error("unmapped read not zero");
   a_lo_via_buffer: assert property (byte_wr && (byte_sel == TMCC_SEL_CMPA_LO
      || byte_sel == TMCC_SEL_CMPB_LO) ##1 !byte_wr && !byte_rd ##1 byte_rd
      && !byte_sel[0] && byte_sel != 3'h6 |=> byte_rd_data_r == $past(byte_wr_data, 3))
      else $error("low byte read not from buffer");
   a_hi_write_read: assert property (byte_wr && byte_sel == TMCC_SEL_CMPA_HI
      ##1 !byte_wr ##1 byte_rd && byte_sel == TMCC_SEL_CMPA_HI
      |=> byte_rd_data_r == ($past(byte_wr_data, 3) & hmask))
      else $error("high byte readback wrong");
   a_reserved_still: assert property ((clock_source_select == TMCC_CK_RESERVED
      && counter_run_switch && !byte_wr)[*8]
      |-> !irq_compare_a_r && !irq_period_r && !irq_compare_b_r)
      else $error("count advanced with no clock");
   a_irq_a_single: assert property (irq_compare_a_r |=> !irq_compare_a_r)
      else $error("compare a pulse too long");
   a_irq_p_single: assert property ($rose(irq_period_r) |=> $fell(irq_period_r))
      else $error("period pulse too long");
   a_b_enh_only: assert property ((timer_variant != TMCC_VAR_ENHANCED)[*3]
      |-> !irq_compare_b_r) else $error("compare b irq outside enhanced");
   a_pin_complement: assert property (timer_output_enable_r
      && $past(timer_output_enable_r) && $stable(output_polarity)
      |-> (timer_output_pin_r[1] ^ timer_output_pin_r[0]) == ~^output_polarity)
      else $error("output pair not complementary");
   a_out_disabled: assert property ($past(operating_mode[0])
      |-> !timer_output_enable_r) else $error("output enabled in timer mode");
   a_out_high: assert property (operating_mode == TMCC_MODE_COMPARE
      && output_function == TMCC_OUT_HIGH && irq_compare_a_r
      |-> ##[0:3] timer_output_pin_r[0] == !output_polarity[0])
      else $error("match did not drive pin high");
endmodule
bind tmcc_core tmcc_core_assertions u_tmcc_core_assertions (.clk, .rst, .timer_variant,
   .clock_source_select, .counter_run_switch, .operating_mode, .output_function,
   .output_polarity, .byte_sel, .byte_rd, .byte_wr, .byte_wr_data, .byte_rd_data_r,
   .byte_rd_valid_r, .irq_compare_a_r, .irq_compare_b_r, .irq_period_r,
   .timer_output_pin_r, .timer_output_enable_r);

// [verif/tmcc_core_tb.sv]
// self-checking testbench for the timer core
`timescale 1ns/1ps
module tmcc_core_tb;
   import tmcc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, run = 1'b0, clr_a = 1'b1, byte_rd = 1'b0, byte_wr = 1'b0;
   logic hi_tick = 1'b0, tb_tick = 1'b0, ext, valid, irq_a, irq_b, irq_p, oen;
   logic [1:0] variant = 2'h0, mode = 2'h3, fn = 2'h0, pins;
   logic [2:0] ck = 3'h1, per = 3'h0, sel = 3'h0, ph = 3'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic pause = 1'b0, init_lvl = 1'b1;
   logic [1:0] pol = 2'h2;
   int miscompares = 0, compares = 0, na, nb, np, nh, cyc = 0;
   tmcc_core u_tmcc_core (.clk(clk), .rst(rst), .timer_variant(variant),
      .clock_source_select(ck), .counter_run_switch(run), .counter_pause(pause),
      .period_compare_value(per), .operating_mode(mode), .output_function(fn),
      .output_initial_level(init_lvl), .output_polarity(pol), .clear_on_compare_a(clr_a),
      .high_clk_tick(hi_tick), .timebase_tick(tb_tick), .external_timer_input(ext),
      .byte_sel(sel), .byte_rd(byte_rd), .byte_wr(byte_wr), .byte_wr_data(wdata),
      .byte_rd_data_r(rdata), .byte_rd_valid_r(valid), .irq_compare_a_r(irq_a),
      .irq_compare_b_r(irq_b), .irq_period_r(irq_p), .timer_output_pin_r(pins),
      .timer_output_enable_r(oen));
   tmcc_ext_src u_tmcc_ext_src (.clk(clk), .pin(ext));
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // high clock every 2 cycles, timebase every 8
   always @(posedge clk)
   begin
      ph <= ph + 3'h1;
      hi_tick <= ph[0];
      tb_tick <= (ph == 3'h7);
   end
   always @(posedge clk)
   begin
      cyc++;
      na += irq_a;
      nb += irq_b;
      np += irq_p;
      nh += pins[0];
      // counts in int would hide unknowns, so flag them here
      if (!rst && $isunknown({irq_a, irq_b, irq_p, pins, oen, valid, rdata}))
      begin
         miscompares++;
         $display("MISMATCH %0t unknown on an output", $time);
      end
      if (cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      compares++;
      if (got != exp)
      begin
         miscompares++;
         $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [2:0] s, input logic [7:0] d);
      @(posedge clk);
      byte_wr <= w;
      byte_rd <= !w;
      sel <= s;
      wdata <= d;
      @(posedge clk);
      byte_wr <= 1'b0;
      byte_rd <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [7:0] exp);
      bus(1'b0, s, 8'h00);
      // valid stands for one cycle only, right after the strobe edge
      #1;
      chk8({7'h0, valid}, 8'h01);
      chk8(rdata, exp);
   endtask
   // low byte first so the high write carries it in
   task automatic wr16(input logic [2:0] hs, input logic [15:0] v);
      bus(1'b1, hs - 3'h1, v[7:0]);
      bus(1'b1, hs, v[15:8]);
   endtask
   // settings change with the counter off, as mode changes demand
   task automatic cfg(input logic [2:0] c, input logic [1:0] v = TMCC_VAR_COMPACT,
      input logic [1:0] m = TMCC_MODE_TIMER, input logic [1:0] f = TMCC_OUT_NONE,
      input logic [2:0] p = 3'h0, input logic ca = 1'b1);
      @(posedge clk);
      run <= 1'b0;
      ck <= c;
      variant <= v;
      mode <= m;
      fn <= f;
      per <= p;
      clr_a <= ca;
      repeat (2) @(posedge clk);
      run <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic win(input int n);
      #1;
      na = 0;
      nb = 0;
      np = 0;
      nh = 0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic t_sources();
      int t[5] = '{4, 1, 32, 128, 8};
      wr16(TMCC_SEL_CMPA_HI, 16'h0001);
      for (int i = 0; i < 5; i++)
      begin
         cfg(3'(i));
         win(2 * t[i]);
         win(20 * t[i]);
         chkn(na, 10);
      end
   endtask
   task automatic t_period();
      cfg(TMCC_CK_SYS, TMCC_VAR_COMPACT, TMCC_MODE_TIMER, TMCC_OUT_NONE, 3'h1, 1'b0);
      win(516);
      chkn(np, 4);
      chk8({7'h0, oen}, 8'h00);
      wr16(TMCC_SEL_CMPB_HI, 16'h0010);
      wr16(TMCC_SEL_CMPA_HI, 16'h001F);
      cfg(TMCC_CK_SYS, TMCC_VAR_ENHANCED);
      win(320);
      chkn(nb, 10);
      chkn(na, 10);
      cfg(TMCC_CK_SYS);
      win(320);
      chkn(nb, 0);
   endtask
   task automatic t_output();
      int e[3] = '{0, 80, 40};
      wr16(TMCC_SEL_CMPA_HI, 16'h0007);
      for (int i = 0; i < 3; i++)
      begin
         cfg(TMCC_CK_SYS, TMCC_VAR_COMPACT, TMCC_MODE_COMPARE, 2'(i + 1));
         win(16);
         win(80);
         chkn(nh, e[i]);
      end
      @(posedge clk);
      init_lvl <= 1'b0;
      pol <= 2'h1;
      cfg(TMCC_CK_SYS, TMCC_VAR_COMPACT, TMCC_MODE_COMPARE, TMCC_OUT_NONE);
      win(16);
      chkn(nh, 16);
      chk8({6'h00, pins}, 8'h03);
      chk8({7'h0, oen}, 8'h01);
      wr16(TMCC_SEL_CMPA_HI, 16'h0010);
      cfg(TMCC_CK_SYS, TMCC_VAR_COMPACT, TMCC_MODE_PWM, TMCC_PWM_WAVE, 3'h1, 1'b0);
      win(258);
      // pin 0 inverted: low only for the 16 counts below A, two periods
      chkn(nh, 226);
   endtask
   task automatic t_ext();
      wr16(TMCC_SEL_CMPA_HI, 16'h0003);
      cfg(TMCC_CK_EXT_RISE);
      win(1);
      u_tmcc_ext_src.pulses(3);
      settle();
      chkn(na, 1);
      u_tmcc_ext_src.level(1'b0);
      cfg(TMCC_CK_EXT_FALL);
      win(1);
      u_tmcc_ext_src.pulses(3);
      settle();
      chkn(na, 0);
      u_tmcc_ext_src.level(1'b0);
      settle();
      chkn(na, 1);
      cfg(TMCC_CK_RESERVED);
      win(1);
      u_tmcc_ext_src.pulses(3);
      u_tmcc_ext_src.level(1'b0);
      settle();
      chkn(na, 0);
   endtask
   task automatic t_bytes();
      cfg(TMCC_CK_SYS, TMCC_VAR_STANDARD);
      wr16(TMCC_SEL_CMPA_HI, 16'h0123);
      rd(TMCC_SEL_CMPA_HI, 8'h01);
      rd(TMCC_SEL_CMPA_LO, 8'h23);
      bus(1'b1, TMCC_SEL_CMPA_LO, 8'h77);
      rd(TMCC_SEL_CMPA_LO, 8'h77);
      rd(TMCC_SEL_CMPA_HI, 8'h01);
      rd(TMCC_SEL_CMPA_LO, 8'h23);
      rd(3'h6, 8'h00);
      cfg(TMCC_CK_SYS);
      bus(1'b1, TMCC_SEL_CMPA_HI, 8'hFF);
      rd(TMCC_SEL_CMPA_HI, 8'h03);
      wr16(TMCC_SEL_CMPA_HI, 16'h0100);
      cfg(TMCC_CK_EXT_RISE, TMCC_VAR_STANDARD);
      u_tmcc_ext_src.pulses(5);
      u_tmcc_ext_src.level(1'b0);
      settle();
      @(posedge clk);
      pause <= 1'b1;
      u_tmcc_ext_src.pulses(2);
      u_tmcc_ext_src.level(1'b0);
      settle();
      rd(TMCC_SEL_COUNT_HI, 8'h00);
      rd(TMCC_SEL_COUNT_LO, 8'h05);
      @(posedge clk);
      pause <= 1'b0;
      run <= 1'b0;
      u_tmcc_ext_src.pulses(2);
      u_tmcc_ext_src.level(1'b0);
      settle();
      rd(TMCC_SEL_COUNT_HI, 8'h00);
      rd(TMCC_SEL_COUNT_LO, 8'h05);
      @(posedge clk);
      run <= 1'b1;
      settle();
      rd(TMCC_SEL_COUNT_HI, 8'h00);
      rd(TMCC_SEL_COUNT_LO, 8'h00);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_sources();
      t_period();
      t_output();
      t_ext();
      t_bytes();
      summarize();
   end
endmodule
